// ---- design/apsc_defs.vh ----
// Constants for the amplifier protection and status controller.
// Assumes a 250 MHz system clock; times are given in their own unit and converted here.
`ifndef APSC_DEFS_VH
`define APSC_DEFS_VH
`define APSC_CLK_HZ          250000000
`define APSC_TICK_US         1000
`define APSC_TICK_CYC        ((`APSC_CLK_HZ / 1000000) * `APSC_TICK_US)
`define APSC_WARMUP_MS       150000
`define APSC_OVC_MS          120000
`define APSC_SWR_MS          3000
`define APSC_ODRV_MS         2000
`define APSC_FLASH_MS        250
`define APSC_DEB_MS          5
`define APSC_TICKS(ms)       (((ms) * 1000) / `APSC_TICK_US)
`define APSC_PRST_FLASH      1'b0
// Register map: status, mask, state.
`define APSC_REG_STATUS      12'h000
`define APSC_REG_MASK        12'h004
`define APSC_REG_STATE       12'h008
`define APSC_EVT_WIDTH       5
`define APSC_EVT_OVC         0
`define APSC_EVT_TEMP        1
`define APSC_EVT_SWR         2
`define APSC_EVT_ODRV        3
`define APSC_EVT_EARLY       4
`endif

// ---- design/apsc_debounce.v ----
// Debounce bank: synchronises and filters a group of slow inputs.
// Assumes a one-cycle tick enable; a bit changes only after holding for DEB_TICKS ticks.
`timescale 1ns/10ps
module apsc_debounce #(
  parameter WIDTH     = 8,
  parameter DEB_TICKS = 5
) (
  input  wire             sys_clk,  // System clock.
  input  wire             resetn,   // Synchronous reset, active low.
  input  wire             tick,     // Prescaled tick enable.
  input  wire [WIDTH-1:0] raw,      // Raw inputs.
  output wire [WIDTH-1:0] clean     // Debounced outputs.
);
  reg  [WIDTH-1:0] sync0_ff;
  reg  [WIDTH-1:0] sync1_ff;
  reg  [WIDTH-1:0] clean_ff;
  reg  [7:0]       cnt_ff [0:WIDTH-1];
  integer          i;

  assign clean = clean_ff;

  // ==========================================================
  // Synchroniser and per-bit stability counters.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      sync0_ff <= {WIDTH{1'b0}};
      sync1_ff <= {WIDTH{1'b0}};
      clean_ff <= {WIDTH{1'b0}};
      for (i = 0; i < WIDTH; i = i + 1) begin
        cnt_ff[i] <= 8'h00;
      end
    end else begin
      sync0_ff <= raw;
      sync1_ff <= sync0_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (sync1_ff[i] == clean_ff[i]) begin
          cnt_ff[i] <= 8'h00;
        end else if (tick) begin
          if (cnt_ff[i] >= DEB_TICKS[7:0] - 8'h01) begin
            clean_ff[i] <= sync1_ff[i];
            cnt_ff[i]   <= 8'h00;
          end else begin
            cnt_ff[i] <= cnt_ff[i] + 8'h01;
          end
        end
      end
    end
  end
endmodule // apsc_debounce

// ---- design/apsc_ctrl.v ----
// Protection and status sequencer of an HF power amplifier controller board.
// Assumes comparator, switch and key inputs are asynchronous levels, synchronised here; APB slave.
// Summary of operation
// - On-air lamp lights while key line asserted and operate selected.
// - Ready stays off after power-up until warm-up timer expires.
// - Plate over-current drops ready two minutes; fault lit then if operate.
// - Over-temperature lights fault, disables amp, screen off, bypass until safe.
// - Operate at power-up lights fault during warm-up, cleared at ready.
// - High SWR lights SWR lamp and forces bypass about three seconds.
// - Overdrive lamp flashes past linear level; higher level bypasses two seconds.
// - Screen current above full scale flashes red segments; limiter near 60 mA.
// - Plate current above 1.8A shown red; flashes, like screen bar only.
// - Output power bar red above 1.5kW, yellow below.
// - Antenna to amp on transmit; bypass in standby, cut-offs, errors.
// - Full bias while drive sensed on transmit; pre-bias as soon as drive drops.
// - Drive ready, SWR, overdrive and antenna relays separately.
// - Standby keeps screen off and bypasses RF; standby at power-on.
// - Fault lit when operate selected before ready.
`timescale 1ns/10ps
`include "apsc_defs.vh"
module apsc_ctrl #(
  parameter TICK_CYC     = `APSC_TICK_CYC,
  parameter WARMUP_TICKS = `APSC_TICKS(`APSC_WARMUP_MS),
  parameter OVC_TICKS    = `APSC_TICKS(`APSC_OVC_MS),
  parameter SWR_TICKS    = `APSC_TICKS(`APSC_SWR_MS),
  parameter ODRV_TICKS   = `APSC_TICKS(`APSC_ODRV_MS),
  parameter FLASH_TICKS  = `APSC_TICKS(`APSC_FLASH_MS),
  parameter DEB_TICKS    = `APSC_TICKS(`APSC_DEB_MS)
) (
  input  wire        sys_clk,                 // System clock, 250 MHz.
  input  wire        resetn,                  // Synchronous reset, active low.
  input  wire        psel,                    // APB select.
  input  wire        penable,                 // APB enable.
  input  wire        pwrite,                  // APB write.
  input  wire [11:0] paddr,                   // APB byte address.
  input  wire [31:0] pwdata,                  // APB write data.
  output wire        pready,                  // APB ready.
  output reg  [31:0] prdata,                  // APB read data.
  output wire        pslverr,                 // APB error on unmapped address.
  output wire        irq,                     // Interrupt, level, active high.
  input  wire        operate_standby_select,  // High when operate selected.
  input  wire        key_line,                // Transceiver key line, high on transmit.
  input  wire        drive_sense,             // RF drive above detection threshold.
  input  wire        plate_ovc_cmp,           // Plate over-current comparator.
  input  wire        temp_hot_cmp,            // Over-temperature comparator.
  input  wire        swr_high_cmp,            // Reflected power beyond threshold.
  input  wire        odrv_lin_cmp,            // Drive past linear level.
  input  wire        odrv_high_cmp,           // Drive at cut-off level.
  input  wire        screen_fs_cmp,           // Screen current above full scale.
  input  wire        screen_lim_cmp,          // Screen current at limiter level.
  input  wire        plate_red_cmp,           // Plate current above red mark.
  input  wire        power_red_cmp,           // Output power above red mark.
  output reg         on_air_led,              // On-air lamp.
  output reg         ready_led,               // Ready lamp.
  output reg         fault_led,               // Fault lamp.
  output reg         swr_led,                 // SWR cut-off lamp.
  output reg         odrv_led,                // Overdrive lamp.
  output reg         screen_red_flash,        // Screen bar red segments lit.
  output reg         screen_limit,            // Screen current limiter engaged.
  output reg         plate_red_flash,         // Plate bar red segments lit.
  output reg         power_red,               // Output bar red zone.
  output reg         power_yellow,            // Output bar yellow zone.
  output reg         drive_sensed_bias_switch,// Full bias enable, low for pre-bias.
  output reg         screen_enable,           // Screen supply enable.
  output reg         amp_enable,              // Amplification enable.
  output reg         ready_relay,             // Ready relay.
  output reg         swr_relay,               // SWR relay.
  output reg         odrv_relay,              // Overdrive relay.
  output reg         antenna_relay            // High: antenna to amplifier.
);
  localparam ST_WARM = 2'b00;
  localparam ST_RDY  = 2'b01;
  localparam ST_OVC  = 2'b10;

  // Saturating countdown step for the main, SWR and overdrive tick timers.
  function [31:0] dec_sat;
    input [31:0] v;
    begin
      dec_sat = (v == 32'h00000000) ? 32'h00000000 : v - 32'h00000001;
    end
  endfunction

  reg  [31:0] pre_ff;
  reg         tick_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [31:0] main_tmr_ff;
  reg  [31:0] swr_tmr_ff;
  reg  [31:0] odrv_tmr_ff;
  reg  [31:0] flash_tmr_ff;
  reg         flash_ff;
  reg         boot_opr_ff;
  reg         early_opr_ff;
  reg  [`APSC_EVT_WIDTH-1:0] status_ff;
  reg  [`APSC_EVT_WIDTH-1:0] mask_ff;
  reg  [`APSC_EVT_WIDTH-1:0] evt_prev_ff;
  wire [10:0] in_clean;
  wire        opr, key, drv, ovc, hot, swr, olin, ohigh, sfs, slim, pred, wred;
  wire        swr_cut, odrv_cut, bypass, tx, in_warm;
  wire [`APSC_EVT_WIDTH-1:0] evt_lvl;
  wire [`APSC_EVT_WIDTH-1:0] evt_rise;
  wire        wr_en, rd_en;

  // ==========================================================
  // Tick prescaler.
  // tick prescaler
  always @(posedge sys_clk) begin
    if (!resetn) begin
      pre_ff  <= 32'h00000000;
      tick_ff <= 1'b0;
    end else if (pre_ff >= TICK_CYC - 1) begin
      pre_ff  <= 32'h00000000;
      tick_ff <= 1'b1;
    end else begin
      pre_ff  <= pre_ff + 32'h00000001;
      tick_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Input conditioning.
  // synchronise and debounce
  apsc_debounce #(
    .WIDTH     (11),
    .DEB_TICKS (DEB_TICKS)
  ) u_deb (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (tick_ff),
    .raw     ({power_red_cmp, plate_red_cmp, screen_lim_cmp, screen_fs_cmp,
               odrv_high_cmp, odrv_lin_cmp, swr_high_cmp, temp_hot_cmp,
               plate_ovc_cmp, key_line, operate_standby_select}),
    .clean   (in_clean)
  );
  assign {wred, pred, slim, sfs, ohigh, olin, swr, hot, ovc, key, opr} = in_clean;

  // Drive sense is kept fast so bias follows speech pauses at once.
  reg drv_s0_ff, drv_s1_ff;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      drv_s0_ff <= 1'b0;
      drv_s1_ff <= 1'b0;
    end else begin
      drv_s0_ff <= drive_sense;
      drv_s1_ff <= drv_s0_ff;
    end
  end
  assign drv = drv_s1_ff;

  // ==========================================================
  // Warm-up, ready and over-current sequencer.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WARM: begin
        if (main_tmr_ff == 32'h00000000) nxt_state = ST_RDY;
      end
      ST_RDY: begin
        if (ovc) nxt_state = ST_OVC;
      end
      ST_OVC: begin
        if (main_tmr_ff == 32'h00000000) nxt_state = ST_RDY;
      end
      default: nxt_state = ST_WARM;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff    <= ST_WARM;
      main_tmr_ff <= WARMUP_TICKS;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_RDY && nxt_state == ST_OVC) begin
        main_tmr_ff <= OVC_TICKS;
      end else if (tick_ff) begin
        main_tmr_ff <= dec_sat(main_tmr_ff);
      end
    end
  end
  assign in_warm = (state_ff == ST_WARM);

  // ==========================================================
  // Cut-off timers and flash rate.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      swr_tmr_ff   <= 32'h00000000;
      odrv_tmr_ff  <= 32'h00000000;
      flash_tmr_ff <= 32'h00000000;
      flash_ff     <= `APSC_PRST_FLASH;
    end else begin
      if (swr) swr_tmr_ff <= SWR_TICKS;
      else if (tick_ff) swr_tmr_ff <= dec_sat(swr_tmr_ff);

      if (ohigh) odrv_tmr_ff <= ODRV_TICKS;
      else if (tick_ff) odrv_tmr_ff <= dec_sat(odrv_tmr_ff);

      if (tick_ff) begin
        if (flash_tmr_ff == 32'h00000000) begin
          flash_tmr_ff <= FLASH_TICKS - 1;
          flash_ff     <= ~flash_ff;
        end else begin
          flash_tmr_ff <= flash_tmr_ff - 32'h00000001;
        end
      end
    end
  end
  assign swr_cut  = swr | (swr_tmr_ff != 32'h00000000);
  assign odrv_cut = ohigh | (odrv_tmr_ff != 32'h00000000);

  // ==========================================================
  // Operate selection faults.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      boot_opr_ff  <= 1'b0;
      early_opr_ff <= 1'b0;
    end else begin
      // The window allows for the selector's debounce delay after reset.
      // operate at power-up
      if (in_warm && main_tmr_ff >= WARMUP_TICKS - DEB_TICKS - 2 && opr) boot_opr_ff <= 1'b1;
      else if (!in_warm) boot_opr_ff <= 1'b0;

      early_opr_ff <= in_warm & opr;
    end
  end

  // ==========================================================
  // Outputs.
  // bypass conditions
  assign bypass = ~opr | (state_ff != ST_RDY) | hot | swr_cut | odrv_cut;
  assign tx     = key & ~bypass;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      on_air_led               <= 1'b0;
      ready_led                <= 1'b0;
      fault_led                <= 1'b0;
      swr_led                  <= 1'b0;
      odrv_led                 <= 1'b0;
      screen_red_flash         <= 1'b0;
      screen_limit             <= 1'b0;
      plate_red_flash          <= 1'b0;
      power_red                <= 1'b0;
      power_yellow             <= 1'b0;
      drive_sensed_bias_switch <= 1'b0;
      screen_enable            <= 1'b0;
      amp_enable               <= 1'b0;
      ready_relay              <= 1'b0;
      swr_relay                <= 1'b0;
      odrv_relay               <= 1'b0;
      antenna_relay            <= 1'b0;
    end else begin
      on_air_led <= key & opr;

      ready_led <= (state_ff == ST_RDY);

      fault_led <= hot | ((state_ff == ST_OVC) & opr) | boot_opr_ff | early_opr_ff;

      swr_led <= swr_cut;

      odrv_led <= (olin & flash_ff) | odrv_cut;

      screen_red_flash <= sfs & flash_ff;
      screen_limit     <= slim;

      plate_red_flash <= pred & flash_ff;

      power_red    <= wred;
      power_yellow <= ~wred;

      drive_sensed_bias_switch <= tx & drv;

      screen_enable <= opr & (state_ff == ST_RDY) & ~hot;
      amp_enable    <= ~bypass;

      ready_relay   <= (state_ff == ST_RDY);
      swr_relay     <= swr_cut;
      odrv_relay    <= odrv_cut;
      antenna_relay <= tx;
    end
  end

  // ==========================================================
  // Interrupt status, set on event rise, cleared by writing one.
  assign evt_lvl  = {in_warm & opr, ohigh, swr, hot, state_ff == ST_OVC};
  assign evt_rise = evt_lvl & ~evt_prev_ff;
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & ~penable & ~pwrite;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      evt_prev_ff <= {`APSC_EVT_WIDTH{1'b0}};
      status_ff   <= {`APSC_EVT_WIDTH{1'b0}};
      mask_ff     <= {`APSC_EVT_WIDTH{1'b0}};
    end else begin
      evt_prev_ff <= evt_lvl;
      if (wr_en && paddr == `APSC_REG_STATUS) begin
        status_ff <= (status_ff & ~pwdata[`APSC_EVT_WIDTH-1:0]) | evt_rise;
      end else begin
        status_ff <= status_ff | evt_rise;
      end
      if (wr_en && paddr == `APSC_REG_MASK) mask_ff <= pwdata[`APSC_EVT_WIDTH-1:0];
    end
  end
  assign irq = |(status_ff & mask_ff);

  // ==========================================================
  // APB read path, data registered in the setup cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr != `APSC_REG_STATUS) &
                   (paddr != `APSC_REG_MASK) & (paddr != `APSC_REG_STATE);
  always @(posedge sys_clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `APSC_REG_STATUS: prdata <= {27'h0000000, status_ff};
        `APSC_REG_MASK:   prdata <= {27'h0000000, mask_ff};
        `APSC_REG_STATE:  prdata <= {24'h000000, hot, swr_cut, odrv_cut, tx,
                                     opr, key, state_ff};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // apsc_ctrl

// ---- tb/apsc_ctrl_properties.sv ----
// Port-level timing checks for the amplifier protection controller.
// Assumes a bind to apsc_ctrl with the same tick, warm-up and debounce parameters.
`timescale 1ns/10ps
module apsc_ctrl_properties #(
  parameter TICK_CYC     = 4,
  parameter WARMUP_TICKS = 20,
  parameter DEB_TICKS    = 2
) (
  input wire sys_clk,                  // Clock.
  input wire resetn,                   // Reset.
  input wire operate_standby_select,   // Selector.
  input wire key_line,                 // Key.
  input wire drive_sense,              // Drive.
  input wire temp_hot_cmp,             // Hot.
  input wire odrv_high_cmp,            // Cut level.
  input reg  on_air_led,               // Lamp.
  input reg  ready_led,                // Lamp.
  input reg  fault_led,                // Lamp.
  input reg  swr_led,                  // Lamp.
  input reg  odrv_led,                 // Lamp.
  input reg  power_red,                // Bar.
  input reg  power_yellow,             // Bar.
  input reg  drive_sensed_bias_switch, // Bias.
  input reg  screen_enable,            // Screen.
  input reg  amp_enable,               // Amp.
  input reg  ready_relay,              // Relay.
  input reg  swr_relay,                // Relay.
  input reg  antenna_relay             // Relay.
);
  localparam int DLY      = 2 + (DEB_TICKS + 2) * TICK_CYC + 4;
  localparam int WARM_CYC = (WARMUP_TICKS - 1) * TICK_CYC;
  logic [31:0] up_ff, hot_ff, stb_ff, odh_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Helper counters of cycles since reset and of held inputs.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      up_ff  <= 32'h00000000;
      hot_ff <= 32'h00000000;
      stb_ff <= 32'h00000000;
      odh_ff <= 32'h00000000;
    end else begin
      up_ff  <= up_ff + 32'h00000001;
      hot_ff <= temp_hot_cmp ? hot_ff + 32'h00000001 : 32'h00000000;
      stb_ff <= !operate_standby_select ? stb_ff + 32'h00000001 : 32'h00000000;
      odh_ff <= odrv_high_cmp ? odh_ff + 32'h00000001 : 32'h00000000;
    end
  end
  // ==========================================================
  // Properties.
  sequence s_gap;
    $fell(drive_sense) ##1 drive_sense;
  endsequence
  sequence s_cut;
    ##1 (swr_led && !antenna_relay)[*7];
  endsequence
  property p_onair;
    $rose(on_air_led) |-> $past(key_line) && $past(operate_standby_select);
  endproperty
  property p_warm;
    (up_ff < WARM_CYC) |-> !ready_led;
  endproperty
  property p_hot;
    (hot_ff >= DLY) |-> fault_led && !amp_enable && !screen_enable && !antenna_relay;
  endproperty
  property p_stby;
    (stb_ff >= DLY) |-> !screen_enable && !antenna_relay;
  endproperty
  property p_odrv;
    (odh_ff >= DLY) |-> odrv_led && !antenna_relay;
  endproperty
  property p_swr;
    $rose(swr_led) |-> s_cut;
  endproperty
  property p_prebias;
    s_gap |-> ##[0:4] !drive_sensed_bias_switch;
  endproperty
  property p_relay;
    ready_relay == ready_led && swr_relay == swr_led;
  endproperty
  property p_power;
    (up_ff > 2) |-> power_red != power_yellow;
  endproperty
  a_onair: assert property (p_onair) else $error("on-air lamp without key");
  a_warm: assert property (p_warm) else $error("ready before warm-up");
  a_hot: assert property (p_hot) else $error("hot tube not shut down");
  a_stby: assert property (p_stby) else $error("standby not bypassed");
  a_odrv: assert property (p_odrv) else $error("overdrive cut missing");
  a_swr: assert property (p_swr) else $error("swr cut too short");
  a_prebias: assert property (p_prebias) else $error("bias kept on drive gap");
  a_relay: assert property (p_relay) else $error("relay differs from lamp");
  a_power: assert property (p_power) else $error("power bar zone wrong");
endmodule // apsc_ctrl_properties

// ---- tb/apsc_xcvr_model.sv ----
// Station transceiver model: keys the amplifier and supplies RF drive.
// Assumes the bench commands keying; drive follows the key after a set lag.
`timescale 1ns/10ps
module apsc_xcvr_model (
  input  wire       sys_clk,    // Clock.
  input  wire       resetn,     // Reset, active low.
  input  wire       key_req,    // Bench asks for transmit.
  input  wire       drop_req,   // Bench asks for a drive gap.
  input  wire [3:0] lag,        // Cycles from key to drive.
  output logic      key_line,   // Key line.
  output logic      drive_sense // Drive present.
);
  logic [3:0] cnt_ff;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      key_line    <= 1'b0;
      drive_sense <= 1'b0;
      cnt_ff      <= 4'h0;
    end else begin
      key_line    <= key_req;
      cnt_ff      <= !key_req ? 4'h0 : (cnt_ff == lag) ? cnt_ff : cnt_ff + 4'h1;
      drive_sense <= key_req && (cnt_ff == lag) && !drop_req;
    end
  end
endmodule // apsc_xcvr_model

// ---- tb/apsc_ctrl_test.sv ----
// Self-checking bench for the protection controller with shortened timers.
// Assumes the design sources and the transceiver model are compiled first.
`timescale 1ns/10ps
module apsc_ctrl_test;
  localparam int TCK = 4, WRM = 20, OVC = 30, SWR = 10, ODR = 8, DEB = 2;
  localparam int SETTLE = 2 + (DEB + 2) * TCK + 4;
  localparam int M_RDY = 0, M_SWR = 2, M_ODL = 3, M_ANT = 4, M_BIAS = 5;
  logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, irq, key_line, drive_sense, key_req = 0, drop_req = 0;
  logic [3:0] lag = 4'h6;
  logic operate_standby_select = 0, plate_ovc_cmp = 0, temp_hot_cmp = 0, swr_high_cmp = 0;
  logic odrv_lin_cmp = 0, odrv_high_cmp = 0, screen_fs_cmp = 0, screen_lim_cmp = 0;
  logic plate_red_cmp = 0, power_red_cmp = 0;
  logic on_air_led, ready_led, fault_led, swr_led, odrv_led, screen_red_flash, screen_limit;
  logic plate_red_flash, power_red, power_yellow, drive_sensed_bias_switch, screen_enable;
  logic amp_enable, ready_relay, swr_relay, odrv_relay, antenna_relay;
  int err_total = 0, check_count = 0;
  wire [8:0] mon = {power_red, plate_red_flash, screen_red_flash, drive_sensed_bias_switch,
                    antenna_relay, odrv_led, swr_led, fault_led, ready_led};
  apsc_ctrl #(.TICK_CYC(TCK), .WARMUP_TICKS(WRM), .OVC_TICKS(OVC), .SWR_TICKS(SWR),
    .ODRV_TICKS(ODR), .FLASH_TICKS(2), .DEB_TICKS(DEB)) i_dut (.sys_clk, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq,
    .operate_standby_select, .key_line, .drive_sense, .plate_ovc_cmp, .temp_hot_cmp,
    .swr_high_cmp, .odrv_lin_cmp, .odrv_high_cmp, .screen_fs_cmp, .screen_lim_cmp,
    .plate_red_cmp, .power_red_cmp, .on_air_led, .ready_led, .fault_led, .swr_led, .odrv_led,
    .screen_red_flash, .screen_limit, .plate_red_flash, .power_red, .power_yellow,
    .drive_sensed_bias_switch, .screen_enable, .amp_enable, .ready_relay, .swr_relay,
    .odrv_relay, .antenna_relay);
  apsc_xcvr_model i_xcvr (.sys_clk, .resetn, .key_req, .drop_req, .lag, .key_line,
    .drive_sense);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_lvl(input int b, input logic v, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge sys_clk);
      if (mon[b] === v) break;
    end
  endtask
  task automatic toggles(input int b, output int n);
    logic p;
    n = 0;
    p = mon[b];
    repeat (48) begin
      @(posedge sys_clk);
      if (mon[b] !== p) n++;
      p = mon[b];
    end
  endtask
  task automatic do_reset(input logic o);
    @(posedge sys_clk);
    resetn <= 1'b0;
    operate_standby_select <= o;
    cyc(16);
    resetn <= 1'b1;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_warm();
    int n;
    do_reset(1'b0);
    cyc((WRM - 1) * TCK - 1);
    chk("ready_early", ready_led, 0);
    chk("screen_stby", screen_enable, 0);
    chk("bypass_stby", antenna_relay, 0);
    wait_lvl(M_RDY, 1'b1, 60, n);
    chk("ready_late", n < 60, 1);
    apb(1'b0, 12'h004, 32'h0);
    chk("mask_rst", rd, 0);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", perr, 1);
    $display("test warm done");
  endtask
  task automatic t_early();
    int n;
    do_reset(1'b1);
    cyc(SETTLE);
    chk("fault_warm", fault_led, 1);
    apb(1'b1, 12'h004, 32'h10);
    cyc(1);
    chk("irq_early", irq, 1);
    wait_lvl(M_RDY, 1'b1, 100, n);
    cyc(2);
    chk("fault_clear", fault_led, 0);
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b0, 12'h000, 32'h0);
    chk("status_w1c", rd, 0);
    $display("test early done");
  endtask
  task automatic t_key();
    int n;
    key_req <= 1'b1;
    cyc(SETTLE + 12);
    chk("on_air", on_air_led, 1);
    chk("ant_tx", antenna_relay, 1);
    chk("bias_full", drive_sensed_bias_switch, 1);
    chk("amp_on", {amp_enable, screen_enable, ready_relay}, 3'h7);
    drop_req <= 1'b1;
    cyc(1);
    drop_req <= 1'b0;
    wait_lvl(M_BIAS, 1'b0, 6, n);
    chk("bias_gap", n < 6, 1);
    key_req <= 1'b0;
    cyc(SETTLE + 4);
    chk("rx", {on_air_led, antenna_relay}, 0);
    $display("test key done");
  endtask
  task automatic t_swr();
    int n;
    lag <= 4'h1;
    key_req <= 1'b1;
    swr_high_cmp <= 1'b1;
    cyc(SETTLE + 4);
    swr_high_cmp <= 1'b0;
    chk("swr_cut", {swr_led, antenna_relay}, 2'h2);
    wait_lvl(M_SWR, 1'b0, SWR * TCK + 3 * SETTLE, n);
    chk("swr_len", n >= (SWR - 1) * TCK && n < SWR * TCK + 3 * SETTLE, 1);
    apb(1'b1, 12'h004, 32'h0);
    chk("irq_masked", irq, 0);
    apb(1'b1, 12'h004, 32'h4);
    chk("irq_swr", irq, 1);
    apb(1'b1, 12'h000, 32'h4);
    chk("irq_clr", irq, 0);
    $display("test swr done");
  endtask
  task automatic t_odrv();
    int n;
    odrv_lin_cmp <= 1'b1;
    cyc(SETTLE);
    toggles(M_ODL, n);
    chk("odrv_flash", n >= 3, 1);
    odrv_high_cmp <= 1'b1;
    cyc(SETTLE + 4);
    odrv_high_cmp <= 1'b0;
    odrv_lin_cmp <= 1'b0;
    chk("odrv_cut", {odrv_relay, antenna_relay}, 2'h2);
    wait_lvl(M_ANT, 1'b1, ODR * TCK + 3 * SETTLE, n);
    chk("odrv_len", n >= (ODR - 1) * TCK && n < ODR * TCK + 3 * SETTLE, 1);
    $display("test odrv done");
  endtask
  task automatic t_temp();
    temp_hot_cmp <= 1'b1;
    cyc(SETTLE + 4);
    chk("hot", {fault_led, amp_enable, screen_enable, antenna_relay}, 4'h8);
    temp_hot_cmp <= 1'b0;
    cyc(SETTLE + 4);
    chk("cool", {fault_led, amp_enable, screen_enable, antenna_relay}, 4'h7);
    $display("test temp done");
  endtask
  task automatic t_ovc();
    int n;
    key_req <= 1'b0;
    plate_ovc_cmp <= 1'b1;
    cyc(SETTLE);
    plate_ovc_cmp <= 1'b0;
    chk("ovc_trip", {ready_led, fault_led}, 2'h1);
    wait_lvl(M_RDY, 1'b1, OVC * TCK + 2 * SETTLE, n);
    chk("ovc_len", n >= (OVC - 1) * TCK - SETTLE && n < OVC * TCK + 2 * SETTLE, 1);
    cyc(2);
    chk("ovc_end", fault_led, 0);
    $display("test ovc done");
  endtask
  task automatic t_bars();
    int n;
    {screen_fs_cmp, screen_lim_cmp, plate_red_cmp, power_red_cmp} <= 4'hF;
    cyc(SETTLE);
    chk("limit", screen_limit, 1);
    chk("pwr_red", {power_red, power_yellow}, 2'h2);
    toggles(6, n);
    chk("scr_flash", n >= 3, 1);
    toggles(7, n);
    chk("plate_flash", n >= 3, 1);
    toggles(8, n);
    chk("pwr_steady", n, 0);
    {screen_fs_cmp, screen_lim_cmp, plate_red_cmp, power_red_cmp} <= 4'h0;
    cyc(SETTLE + 12);
    chk("bars_off", {screen_limit, screen_red_flash, plate_red_flash, power_yellow}, 1);
    $display("test bars done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    t_warm();
    t_early();
    t_key();
    t_swr();
    t_odrv();
    t_temp();
    t_ovc();
    t_bars();
    final_report();
  end
  initial begin
    #40000;
    err_total++;
    final_report();
  end
endmodule // apsc_ctrl_test
bind apsc_ctrl apsc_ctrl_properties #(.TICK_CYC(TICK_CYC), .WARMUP_TICKS(WARMUP_TICKS),
  .DEB_TICKS(DEB_TICKS)) i_props (.sys_clk, .resetn, .operate_standby_select, .key_line,
  .drive_sense, .temp_hot_cmp, .odrv_high_cmp, .on_air_led, .ready_led, .fault_led, .swr_led,
  .odrv_led, .power_red, .power_yellow, .drive_sensed_bias_switch, .screen_enable,
  .amp_enable, .ready_relay, .swr_relay, .antenna_relay);
